// *** hw/rcc_control_regs.sv ***
// Pin routing, retry status and slot control configuration registers
`timescale 1ns/1ps
`default_nettype none
`include "rcc_regs.svh"
module rcc_control_regs
    import rcc_pkg::*;
#(
    parameter int RETRY_LIMIT = `RCC_RETRY_LIMIT_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    input wire rcc_cfg_req_t cfg_req,
    input wire rcc_pins_t pins,
    input wire logic host_retry_issued,
    input wire logic host_retry_returned,
    input wire logic [1:0] card_retry_issued,
    input wire logic [1:0] card_retry_returned,
    output logic [7:0] cfg_rdata,
    output logic cfg_rvalid,
    output var rcc_pin_sel_t pin_select,
    output logic [2:0] general_input,
    output logic ring_indicate_pin,
    output logic [1:0] video_port_tristate,
    output logic audio_pulse_width_output,
    output logic host_speaker_pin,
    output logic host_speaker_oe_n
);
    // Input synchronisers
    rcc_pins_t sync1_reg;
    rcc_pins_t sync2_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= pins;
            sync2_reg <= sync1_reg;
        end
    end

    // Decoded accesses
    logic wr_route_lo;
    logic wr_route_hi;
    logic wr_retry;
    logic wr_card;
    logic [7:0] wd;
    logic fn;

    assign wd = cfg_req.wdata;
    assign fn = cfg_req.func;
    assign wr_route_lo = cfg_req.wr && cfg_req.addr == `RCC_ROUTE_LO_OFF;
    assign wr_route_hi = cfg_req.wr && cfg_req.addr == `RCC_ROUTE_HI_OFF;
    assign wr_retry = cfg_req.wr && cfg_req.addr == `RCC_RETRY_OFF;
    assign wr_card = cfg_req.wr && cfg_req.addr == `RCC_CARD_OFF;

    // Pin routing selects, shared by both functions
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_select <= '{`RCC_SEL_RESET, `RCC_SEL_RESET, `RCC_SEL_RESET};
        end else begin
            if (wr_route_lo) begin
                pin_select.pin0 <= wd[2:0];
                pin_select.pin1 <= wd[6:4];
            end
            if (wr_route_hi) begin
                pin_select.pin2 <= wd[2:0];
            end
        end
    end

    // Pins routed as general inputs when their select is zero
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            general_input <= 3'h0;
        end else begin
            general_input[0] <= (pin_select.pin0 == `RCC_SEL_GENERAL_INPUT)
                && sync2_reg.multi_pin[0];
            general_input[1] <= (pin_select.pin1 == `RCC_SEL_GENERAL_INPUT)
                && sync2_reg.multi_pin[1];
            general_input[2] <= (pin_select.pin2 == `RCC_SEL_GENERAL_INPUT)
                && sync2_reg.multi_pin[2];
        end
    end

    // Retry counter enables, global
    logic host_en_reg;
    logic card_en_reg;
    localparam logic [7:0] RETRY_RST = `RCC_RETRY_RESET;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            host_en_reg <= RETRY_RST[`RCC_HOST_EN_BIT];
            card_en_reg <= RETRY_RST[`RCC_CARD_EN_BIT];
        end else if (wr_retry) begin
            host_en_reg <= wd[`RCC_HOST_EN_BIT];
            card_en_reg <= wd[`RCC_CARD_EN_BIT];
        end
    end

    // Retry timers and expiry flags: 0 host, 1 card A, 2 card B
    logic [2:0] timer_issued;
    logic [2:0] timer_returned;
    logic [2:0] timer_enable;
    logic [2:0] timer_exp;
    logic [2:0] expired_reg;

    assign timer_issued = {card_retry_issued, host_retry_issued};
    assign timer_returned = {card_retry_returned, host_retry_returned};
    assign timer_enable = {card_en_reg, card_en_reg, host_en_reg};

    for (genvar i = 0; i < 3; i++) begin : g_retry
        localparam int P = (i == 0) ? `RCC_EXP_HOST_BIT :
            (i == 1) ? `RCC_EXP_A_BIT : `RCC_EXP_B_BIT;

        rcc_retry_timer #(
            .LIMIT(RETRY_LIMIT)
        ) u_timer (
            .clk(clk),
            .reset(reset),
            .enable(timer_enable[i]),
            .issued(timer_issued[i]),
            .returned(timer_returned[i]),
            .expired(timer_exp[i])
        );

        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                expired_reg[i] <= 1'b0;
            end else if (timer_exp[i]) begin
                expired_reg[i] <= 1'b1;
            end else if (wr_retry && wd[P]) begin
                expired_reg[i] <= 1'b0;
            end
        end
    end

    // Slot control: ring enable global, the rest per function
    logic ring_en_reg;
    logic [1:0] spare_reg;
    logic [1:0] aud_dis_reg;
    logic [1:0] spk_en_reg;
    logic [1:0] ifg_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ring_en_reg <= 1'b0;
        end else if (wr_card) begin
            ring_en_reg <= wd[`RCC_RING_EN_BIT];
        end
    end

    // Spare bit is not global-reset only: the bus reset clears it too
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            spare_reg <= 2'h0;
        end else if (sync2_reg.bus_reset) begin
            spare_reg <= 2'h0;
        end else if (wr_card) begin
            spare_reg[fn] <= wd[`RCC_SPARE_BIT];
        end
    end

    for (genvar s = 0; s < 2; s++) begin : g_slot
        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                video_port_tristate[s] <= 1'b0;
                aud_dis_reg[s] <= 1'b0;
                spk_en_reg[s] <= 1'b0;
            end else if (wr_card && fn == s) begin
                video_port_tristate[s] <= wd[`RCC_VIDEO_BIT];
                aud_dis_reg[s] <= wd[`RCC_AUDIO_DIS_BIT];
                spk_en_reg[s] <= wd[`RCC_SPEAKER_BIT];
            end
        end

        always_ff @(posedge clk or posedge reset) begin
            if (reset) begin
                ifg_reg[s] <= 1'b0;
            end else if (sync2_reg.irq[s]) begin
                ifg_reg[s] <= 1'b1;
            end else if (wr_card && fn == s && wd[`RCC_IRQ_FLAG_BIT]) begin
                ifg_reg[s] <= 1'b0;
            end
        end
    end

    // Pin outputs
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            ring_indicate_pin <= 1'b0;
            audio_pulse_width_output <= 1'b0;
            host_speaker_pin <= 1'b0;
            host_speaker_oe_n <= 1'b1;
        end else begin
            ring_indicate_pin <= ring_en_reg && |sync2_reg.ring;
            if (!aud_dis_reg[0]) begin
                audio_pulse_width_output <= sync2_reg.audio[0];
            end else if (!aud_dis_reg[1]) begin
                audio_pulse_width_output <= sync2_reg.audio[1];
            end else begin
                audio_pulse_width_output <= 1'b0;
            end
            host_speaker_pin <= (spk_en_reg[0] && sync2_reg.speaker[0])
                ^ (spk_en_reg[1] && sync2_reg.speaker[1]);
            host_speaker_oe_n <= ~|spk_en_reg;
        end
    end

    // Read path, answer one cycle after the request
    logic [7:0] rd_next;

    always_comb begin
        rd_next = 8'h00;
        unique case (cfg_req.addr)
            `RCC_ROUTE_LO_OFF: begin
                rd_next = {1'b0, pin_select.pin1, 1'b0,
                    pin_select.pin0};
            end
            `RCC_ROUTE_HI_OFF: begin
                rd_next = {5'h00, pin_select.pin2};
            end
            `RCC_RETRY_OFF: begin
                rd_next = {host_en_reg, card_en_reg, expired_reg[2], 1'b0,
                    expired_reg[1], 1'b0, expired_reg[0], 1'b0};
            end
            `RCC_CARD_OFF: begin
                rd_next = {ring_en_reg, video_port_tristate[fn],
                    spare_reg[fn], 2'h0, aud_dis_reg[fn], spk_en_reg[fn],
                    ifg_reg[fn]};
            end
            default: begin
                rd_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_rdata <= 8'h00;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_req.rd;
            cfg_rdata <= cfg_req.rd ? rd_next : 8'h00;
        end
    end

    a_route_reserved: assert property (@(posedge clk) disable iff (reset)
        cfg_req.rd && cfg_req.addr == `RCC_ROUTE_LO_OFF
            |=> cfg_rvalid && !cfg_rdata[3] && !cfg_rdata[7]
            && cfg_rdata[2:0] == $past(pin_select.pin0))
        else $error("routing read wrong");

    a_retry_reserved: assert property (@(posedge clk)
        disable iff (reset)
        cfg_req.rd && cfg_req.addr == `RCC_RETRY_OFF
            |=> cfg_rdata[4] == 1'b0 && cfg_rdata[2] == 1'b0
            && cfg_rdata[0] == 1'b0 && cfg_rdata[7] == $past(host_en_reg))
        else $error("retry status read wrong");

    a_card_reserved: assert property (@(posedge clk) disable iff (reset)
        cfg_req.rd && cfg_req.addr == `RCC_CARD_OFF
            |=> cfg_rdata[4:3] == 2'h0 && cfg_rdata[7] == $past(ring_en_reg))
        else $error("card control read wrong");

    a_expiry_sets: assert property (@(posedge clk) disable iff (reset)
        timer_exp[0] |=> expired_reg[0] ##1 (expired_reg[0]
            || $past(wr_retry && wd[`RCC_EXP_HOST_BIT])))
        else $error("host expiry flag not set");

    a_flag_clear: assert property (@(posedge clk) disable iff (reset)
        wr_retry && wd[`RCC_EXP_A_BIT] && !timer_exp[1] |=> !expired_reg[1])
        else $error("card A flag not cleared");

    a_zero_keeps: assert property (@(posedge clk) disable iff (reset)
        expired_reg[2] && !(wr_retry && wd[`RCC_EXP_B_BIT])
            |=> expired_reg[2])
        else $error("card B flag lost");

    a_set_wins: assert property (@(posedge clk) disable iff (reset)
        wr_card && fn == 1'b0 && wd[0] && sync2_reg.irq[0] |=> ifg_reg[0])
        else $error("interrupt flag lost to clear");

    a_speaker_oe: assert property (@(posedge clk) disable iff (reset)
        spk_en_reg == 2'h0 |=> host_speaker_oe_n && !host_speaker_pin)
        else $error("speaker driven while disabled");

    a_ring_gate: assert property (@(posedge clk) disable iff (reset)
        !ring_en_reg |=> !ring_indicate_pin)
        else $error("ring output while disabled");

    a_audio_first: assert property (@(posedge clk) disable iff (reset)
        !aud_dis_reg[0]
            |=> audio_pulse_width_output == $past(sync2_reg.audio[0]))
        else $error("function 0 audio not routed");

    a_keep_global: assert property (@(posedge clk) disable iff (reset)
        sync2_reg.bus_reset && !wr_card && !wr_retry
            |=> $stable(ring_en_reg) && $stable(host_en_reg))
        else $error("global bit lost to bus reset");

    a_video_alias: assert property (@(posedge clk) disable iff (reset)
        wr_card && fn |=> video_port_tristate[1] == $past(wd[`RCC_VIDEO_BIT])
            && $stable(video_port_tristate[0]))
        else $error("function 1 video alias wrong");

endmodule // rcc_control_regs
`default_nettype wire

// *** hw/rcc_regs.svh ***
// Offsets, field positions, reset values and timing counts for the block
// Overview of operation
// - Bits 10:8 select pin 2; 000 is input 2
// - Bits 6:4 select pin 1; 000 is input 1
// - Bits 2:0 select pin 0; 000 is input 0
// - Routing bits 11, 7, 3 read zero
// - Unreturned retry after 2^15 cycles sets flag
// - Write one clears expired flag, else holds
// - Bit 7 enables host retry counter, reset one
// - Bit 6 enables card retry counter, reset one
// - Bit 5 flags card target B expiry
// - Bit 3 flags card target A expiry
// - Bit 1 flags host target expiry
// - Retry status bits 4, 2, 0 read zero
// - Global bits shared; software uses function 0
// - Marked bits cleared only by global reset
// - Card control bit 7 enables ring output
// - Bit 6 tristates that socket's video port
// - Video bit aliases socket enable per function
// - Bit 2 zero routes audio; function 0 wins
// - Bit 1 forwards speakers, sockets XORed
// - Speaker pin drives only when enabled somewhere
// - Bit 0 per-socket interrupt flag, write-one clears
// - Card control bits 4, 3 read zero
`ifndef RCC_REGS_SVH
`define RCC_REGS_SVH

`define RCC_ROUTE_LO_OFF 8'h8C
`define RCC_ROUTE_HI_OFF 8'h8D
`define RCC_RETRY_OFF 8'h90
`define RCC_CARD_OFF 8'h91

`define RCC_RETRY_RESET 8'hC0
`define RCC_CARD_RESET 8'h00
`define RCC_SEL_RESET 3'h0
`define RCC_SEL_GENERAL_INPUT 3'h0

`define RCC_HOST_EN_BIT 7
`define RCC_CARD_EN_BIT 6
`define RCC_EXP_B_BIT 5
`define RCC_EXP_A_BIT 3
`define RCC_EXP_HOST_BIT 1

`define RCC_RING_EN_BIT 7
`define RCC_VIDEO_BIT 6
`define RCC_SPARE_BIT 5
`define RCC_AUDIO_DIS_BIT 2
`define RCC_SPEAKER_BIT 1
`define RCC_IRQ_FLAG_BIT 0

`define RCC_RETRY_LIMIT_CYCLES 32768

`endif

// *** hw/rcc_pkg.sv ***
// Types shared by the retry and slot control logic
package rcc_pkg;

    typedef struct packed {
        logic func;
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } rcc_cfg_req_t;

    typedef struct packed {
        logic [2:0] pin2;
        logic [2:0] pin1;
        logic [2:0] pin0;
    } rcc_pin_sel_t;

    typedef struct packed {
        logic bus_reset;
        logic [2:0] multi_pin;
        logic [1:0] irq;
        logic [1:0] speaker;
        logic [1:0] audio;
        logic [1:0] ring;
    } rcc_pins_t;

    typedef enum logic [1:0] {
        RCC_IDLE = 2'b01,
        RCC_WAIT = 2'b10
    } rcc_timer_state_t;

endpackage

// *** hw/rcc_retry_timer.sv ***
// Retry time-out counter for one target
`timescale 1ns/1ps
`default_nettype none
module rcc_retry_timer
    import rcc_pkg::*;
#(
    parameter int LIMIT = 32768
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic enable,
    input wire logic issued,
    input wire logic returned,
    output logic expired
);
    localparam int CW = $clog2(LIMIT) + 1;

    rcc_timer_state_t state_reg;
    logic [CW-1:0] count_reg;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_reg <= RCC_IDLE;
            count_reg <= '0;
            expired <= 1'b0;
        end else begin
            expired <= 1'b0;
            unique case (state_reg)
                RCC_IDLE: begin
                    count_reg <= '0;
                    if (enable && issued) begin
                        state_reg <= RCC_WAIT;
                    end
                end
                RCC_WAIT: begin
                    if (!enable || returned) begin
                        state_reg <= RCC_IDLE;
                    end else if (count_reg == CW'(LIMIT - 1)) begin
                        expired <= 1'b1;
                        state_reg <= RCC_IDLE;
                    end else begin
                        count_reg <= count_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    a_expire_count: assert property (@(posedge clk) disable iff (reset)
        expired |-> ($past(count_reg) == CW'(LIMIT - 1)
            && $past(state_reg) == RCC_WAIT && $past(enable)))
        else $error("retry expiry without full count");

endmodule // rcc_retry_timer
`default_nettype wire

// *** testbench/rcc_master_model.sv ***
// Model of the host and slot masters that are retried and may come back
`timescale 1ns/1ps
`default_nettype none
module rcc_master_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic [2:0] start,
    input wire logic come_back,
    output logic [2:0] issued,
    output logic [2:0] returned
);
    logic [2:0] back_d1_reg;
    logic [2:0] back_d2_reg;

    // Retry pulse, then a return two cycles later when asked
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            issued <= 3'h0;
            back_d1_reg <= 3'h0;
            back_d2_reg <= 3'h0;
            returned <= 3'h0;
        end else begin
            issued <= start;
            back_d1_reg <= come_back ? start : 3'h0;
            back_d2_reg <= back_d1_reg;
            returned <= back_d2_reg;
        end
    end
endmodule // rcc_master_model
`default_nettype wire

// *** testbench/retry_and_card_control_regs_bench.sv ***
// Self-checking bench for the retry and slot control registers
`timescale 1ns/1ps
`default_nettype none
module retry_and_card_control_regs_bench;
    import rcc_pkg::*;
    localparam int LIM = 16;
    logic clk = 1'b0;
    logic reset = 1'b1;
    rcc_cfg_req_t req = '0;
    rcc_pins_t pins = '0;
    logic [2:0] start = 3'h0;
    logic come_back = 1'b0;
    logic [2:0] issued;
    logic [2:0] returned;
    logic [7:0] cfg_rdata;
    logic cfg_rvalid;
    rcc_pin_sel_t pin_select;
    logic [2:0] general_input;
    logic ring_pin;
    logic [1:0] video_z;
    logic audio_out;
    logic spk_pin;
    logic spk_oe_n;
    logic [7:0] exp_q[$];
    logic [8:0] exp_next;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    logic [31:0] seed = 32'h0000002F;

    always #2 clk = ~clk;

    rcc_master_model far_u (.clk(clk), .reset(reset), .start(start),
        .come_back(come_back), .issued(issued), .returned(returned));

    rcc_control_regs #(.RETRY_LIMIT(LIM)) dut_u (.clk(clk), .reset(reset),
        .cfg_req(req), .pins(pins), .host_retry_issued(issued[0]),
        .host_retry_returned(returned[0]),
        .card_retry_issued(issued[2:1]),
        .card_retry_returned(returned[2:1]), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .pin_select(pin_select),
        .general_input(general_input), .ring_indicate_pin(ring_pin),
        .video_port_tristate(video_z), .audio_pulse_width_output(audio_out),
        .host_speaker_pin(spk_pin), .host_speaker_oe_n(spk_oe_n));

    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [8:0] seen,
                       input logic [8:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic f, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{func: f, addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
    endtask

    // Expected value is noted before the request goes out
    task automatic rd(input logic f, input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        exp_q.push_back(e);
        req = '{func: f, addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(negedge clk);
        req.rd = 1'b0;
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic retry(input logic [2:0] t, input logic back);
        @(negedge clk);
        start = t;
        come_back = back;
        @(negedge clk);
        start = 3'h0;
        idle(LIM + 6);
    endtask

    // Read answers are settled at the falling edge; no note gives 100
    always @(negedge clk) begin
        if (cfg_rvalid !== 1'b0) begin
            if (exp_q.size() > 0) begin
                exp_next = {1'b0, exp_q.pop_front()};
            end else begin
                exp_next = 9'h100;
            end
            chk("read data", {1'b0, cfg_rdata}, exp_next);
        end
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            failures++;
            report_and_stop();
        end
    end

    initial begin
        idle(16);
        reset = 1'b0;
        rd(1'b0, 8'h90, 8'hC0);
        rd(1'b1, 8'h91, 8'h00);
        rd(1'b0, 8'h8D, 8'h00);
        rd(1'b0, 8'h8E, 8'h00);
        wr(1'b0, 8'h8C, 8'hFF);
        wr(1'b0, 8'h8D, 8'hFF);
        rd(1'b0, 8'h8C, 8'h77);
        rd(1'b0, 8'h8D, 8'h07);
        for (int i = 0; i < 8; i++) begin
            seed = xs(seed);
            if (i == 7) seed[15:0] = 16'h0000;
            pins.multi_pin = seed[18:16];
            wr(1'b0, 8'h8C, seed[7:0]);
            wr(1'b0, 8'h8D, seed[15:8]);
            idle(5);
            chk("pin select", pin_select,
                {seed[10:8], seed[6:4], seed[2:0]});
            chk("general input", 9'(general_input),
                9'({seed[10:8] == 3'h0 && seed[18],
                    seed[6:4] == 3'h0 && seed[17],
                    seed[2:0] == 3'h0 && seed[16]}));
        end
        retry(3'h7, 1'b0);
        rd(1'b0, 8'h90, 8'hEA);
        wr(1'b0, 8'h90, 8'hC0);
        rd(1'b0, 8'h90, 8'hEA);
        wr(1'b1, 8'h90, 8'hC2);
        rd(1'b0, 8'h90, 8'hE8);
        wr(1'b0, 8'h90, 8'hE8);
        rd(1'b0, 8'h90, 8'hC0);
        retry(3'h7, 1'b1);
        rd(1'b0, 8'h90, 8'hC0);
        wr(1'b0, 8'h90, 8'h80);
        retry(3'h7, 1'b0);
        rd(1'b0, 8'h90, 8'h82);
        wr(1'b0, 8'h90, 8'h40);
        retry(3'h7, 1'b0);
        rd(1'b0, 8'h90, 8'h6A);
        pins.ring = 2'b01;
        pins.speaker = 2'b11;
        pins.audio = 2'b10;
        wr(1'b0, 8'h91, 8'hFF);
        rd(1'b0, 8'h91, 8'hE6);
        rd(1'b1, 8'h91, 8'h80);
        idle(4);
        chk("ring pin", 9'(ring_pin), 9'h001);
        chk("video", 9'(video_z), 9'h001);
        chk("audio", 9'(audio_out), 9'h001);
        chk("speaker", 9'(spk_pin), 9'h001);
        chk("speaker oe", 9'(spk_oe_n), 9'h000);
        wr(1'b1, 8'h91, 8'h02);
        idle(2);
        chk("speaker", 9'(spk_pin), 9'h000);
        wr(1'b0, 8'h91, 8'h80);
        idle(2);
        chk("audio", 9'(audio_out), 9'h000);
        wr(1'b1, 8'h91, 8'h04);
        idle(2);
        chk("speaker oe", 9'(spk_oe_n), 9'h001);
        chk("video", 9'(video_z), 9'h000);
        pins.irq = 2'b10;
        idle(5);
        pins.irq = 2'b00;
        idle(4);
        rd(1'b1, 8'h91, 8'h05);
        rd(1'b0, 8'h91, 8'h00);
        wr(1'b1, 8'h91, 8'h04);
        rd(1'b1, 8'h91, 8'h05);
        wr(1'b1, 8'h91, 8'h01);
        rd(1'b1, 8'h91, 8'h00);
        pins.irq = 2'b01;
        idle(4);
        wr(1'b0, 8'h91, 8'hE7);
        pins.irq = 2'b00;
        rd(1'b0, 8'h91, 8'hE7);
        wr(1'b0, 8'h8C, 8'h35);
        pins.bus_reset = 1'b1;
        idle(4);
        pins.bus_reset = 1'b0;
        idle(3);
        rd(1'b0, 8'h91, 8'hC7);
        rd(1'b0, 8'h90, 8'h6A);
        rd(1'b0, 8'h8C, 8'h35);
        @(negedge clk);
        reset = 1'b1;
        idle(2);
        reset = 1'b0;
        rd(1'b0, 8'h90, 8'hC0);
        rd(1'b0, 8'h91, 8'h00);
        rd(1'b0, 8'h8C, 8'h00);
        idle(3);
        chk("pending reads", 9'(exp_q.size()), 9'h000);
        report_and_stop();
    end
endmodule // retry_and_card_control_regs_bench
`default_nettype wire
